// ---- logic/caf_top.v ----
// Summary of operation
// RL1: Each message goes to one FIFO only.
// RL2: Lowest-numbered matching filter wins.
// RL3: Full FIFO passes to next matching filter.
// RL4: Software clears type bit for standard-only.
// RL5: Software sets mask type-match bit.
// RL6: Software enables filter after selectors.
// RL7: Software places extended identifier fields.
// RL8: Count field sets data bits; zero disables.
// RL9: Accept when identifier and data bits match.
// RL10: Data filtering applies to standard frames.
// RL11: Data bits run from byte 0 bit 7.
// RL12: Count 18 covers bytes 0, 1, two bits.
// RL13: Counts above 18 stop at bit 18.
// RL14: Length two caps comparison at 16 bits.
// RL15: Length one caps comparison at 8 bits.
// RL16: Length zero compares the identifier alone.
// RL17: Identifier writes ignored while filter enabled.
// RL18: Mask zero bits are left uncompared.
// RL19: Store the accepting filter number.
// RL20: No room anywhere drops and flags overflow.
// RL21: Otherwise compare exactly count bits.
`timescale 1ns/10ps
`include "caf_regs.vh"
module caf_top
#(
	parameter NUM_FILT = 32
)
(
	input wire mclk,
	input wire nrst,
	input wire wb_cyc_i,
	input wire wb_stb_i,
	input wire wb_we_i,
	input wire [8:2] wb_adr_i,
	input wire [3:0] wb_sel_i,
	input wire [31:0] wb_dat_i,
	output reg [31:0] wb_dat_o,
	output reg wb_ack_o,
	input wire msg_valid,
	input wire [10:0] msg_sid,
	input wire [17:0] msg_eid,
	input wire msg_ide,
	input wire [3:0] msg_dlc,
	input wire [7:0] msg_byte0,
	input wire [7:0] msg_byte1,
	input wire [7:0] msg_byte2,
	input wire [31:0] fifo_full,
	output reg msg_ready,
	output reg store_valid,
	output reg [4:0] store_fifo,
	output reg [4:0] filter_hit_number,
	output reg ovfl_valid,
	output reg [4:0] ovfl_fifo
);

	reg [31:0] fid_q [0:NUM_FILT-1];
	reg [31:0] msk_q [0:3];
	reg [7:0] fctl_q [0:NUM_FILT-1];
	reg [4:0] data_filter_bit_count_q;
	reg [10:0] mab_sid_q;
	reg [17:0] mab_eid_q;
	reg mab_ide_q;
	reg [3:0] mab_dlc_q;
	reg [17:0] mab_pay_q;
	reg last_acc_q;
	reg last_ovf_q;
	reg [4:0] last_fifo_q;
	reg [4:0] last_hit_q;
	reg [4:0] dn_n_d;
	reg [3:0] mask_used_d;
	reg [31:0] rdata_d;
	wire [31:0] bmask;
	wire wb_req;
	wire wb_wr;
	wire [8:0] adr;
	wire [4:0] idx;
	wire dn_on;
	wire [17:0] dpay;
	wire [17:0] dlim;
	wire [NUM_FILT-1:0] hit;
	wire [NUM_FILT*5-1:0] fsel_flat;
	wire found;
	wire [4:0] win;
	wire any_hit;
	wire [4:0] first_fifo;
	integer k;
	// Stage states; one message is held and judged at a time.
	localparam ST_IDLE = 1'b0;
	localparam ST_EVAL = 1'b1;

	reg state_q;
	reg state_d;
	wire take_msg;
	wire sel_fid;
	wire sel_msk;
	wire sel_fctl;
	wire sel_mctl;
	wire sel_stat;

	assign wb_req = wb_cyc_i & wb_stb_i;
	assign wb_wr = wb_req & wb_we_i & wb_ack_o;
	assign adr = {wb_adr_i, 2'b00};
	assign idx = wb_adr_i[6:2];
	assign bmask = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}}, {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};

	// One decode feeds both paths, so reads and writes cannot disagree on the map.
	assign sel_fid = (adr < `CAF_OFS_MASK);
	assign sel_msk = (adr >= `CAF_OFS_MASK) && (adr < `CAF_OFS_FCTL)
		&& (wb_adr_i[6:4] == 3'h0);
	assign sel_fctl = (adr >= `CAF_OFS_FCTL) && (adr < `CAF_OFS_MCTL);
	assign sel_mctl = (adr == `CAF_OFS_MCTL);
	assign sel_stat = (adr == `CAF_OFS_STAT);
	assign take_msg = (state_q == ST_IDLE) & msg_valid;

	// Effective number of payload bits, trimmed by the frame's length.
	always @*
	begin
		if (data_filter_bit_count_q > `CAF_DN_MAX)
			dn_n_d = `CAF_DN_MAX; // RL13
		else
			dn_n_d = data_filter_bit_count_q; // RL12 RL21
		if (mab_dlc_q == 4'h0)
			dn_n_d = 5'h00; // RL16
		else if (mab_dlc_q == 4'h1 && dn_n_d > `CAF_DN_ONE_BYTE)
			dn_n_d = `CAF_DN_ONE_BYTE; // RL15
		else if (mab_dlc_q == 4'h2 && dn_n_d > `CAF_DN_TWO_BYTES)
			dn_n_d = `CAF_DN_TWO_BYTES; // RL14
	end

	assign dn_on = (data_filter_bit_count_q != 5'h00); // RL8
	// First received payload bit lands on extended bit n-1.
	assign dpay = mab_pay_q >> (`CAF_DN_MAX - dn_n_d); // RL11
	assign dlim = ~(18'h3_ffff << dn_n_d); // RL11

	genvar g;
	generate
		for (g = 0; g < NUM_FILT; g = g + 1)
		begin : filt
			wire [31:0] m;
			assign m = msk_q[fctl_q[g][`CAF_MSEL_HI:`CAF_MSEL_LO]];
			assign fsel_flat[g*5 +: 5] = fctl_q[g][`CAF_FSEL_HI:0];
			// All filters are compared at once; the priority pick follows.
			caf_match u_match
			(
				.en(fctl_q[g][`CAF_FEN_BIT]),
				.ext_id_enable(fid_q[g][`CAF_TYPE_BIT]),
				.fsid(fid_q[g][`CAF_SID_HI:`CAF_SID_LO]),
				.feid(fid_q[g][`CAF_EID_HI:0]),
				.mask_type_match(m[`CAF_TYPE_BIT]),
				.msid(m[`CAF_SID_HI:`CAF_SID_LO]),
				.meid(m[`CAF_EID_HI:0]),
				.ide(mab_ide_q),
				.sid(mab_sid_q),
				.eid(mab_eid_q),
				.dn_on(dn_on),
				.dpay(dpay),
				.dlim(dlim),
				.hit(hit[g])
			);
		end
	endgenerate

	caf_prio #(.NUM_FILT(NUM_FILT)) u_prio
	(
		.hit(hit),
		.fsel_flat(fsel_flat),
		.fifo_full(fifo_full),
		.found(found),
		.win(win),
		.any_hit(any_hit),
		.first_fifo(first_fifo)
	);

	// A mask stays locked while any enabled filter relies on it.
	always @*
	begin
		mask_used_d = 4'h0;
		for (k = 0; k < NUM_FILT; k = k + 1)
		begin
			if (fctl_q[k][`CAF_FEN_BIT])
				mask_used_d[fctl_q[k][`CAF_MSEL_HI:`CAF_MSEL_LO]] = 1'b1;
		end
	end

	// Unmapped words read as zero.
	always @*
	begin
		rdata_d = `CAF_RST_WORD;
		if (sel_fid)
			rdata_d = fid_q[idx];
		else if (sel_msk)
			rdata_d = msk_q[wb_adr_i[3:2]];
		else if (sel_fctl)
			rdata_d = {24'h00_0000, fctl_q[idx]};
		else if (sel_mctl)
			rdata_d = {27'h000_0000, data_filter_bit_count_q};
		else if (sel_stat)
		begin
			rdata_d[`CAF_ST_HIT_LO +: 5] = last_hit_q;
			rdata_d[`CAF_ST_FIFO_LO +: 5] = last_fifo_q;
			rdata_d[`CAF_ST_ACC_BIT] = last_acc_q;
			rdata_d[`CAF_ST_OVF_BIT] = last_ovf_q;
			rdata_d[`CAF_ST_BUSY_BIT] = ~msg_ready;
		end
	end

	// Acks wait out message evaluation so filters never change mid-message.
	always @(posedge mclk)
	begin
		if (!nrst)
		begin
			wb_ack_o <= 1'b0;
			wb_dat_o <= `CAF_RST_WORD;
		end
		else
		begin
			wb_ack_o <= wb_req & ~wb_ack_o & msg_ready;
			if (wb_req & ~wb_ack_o & msg_ready)
				wb_dat_o <= rdata_d;
		end
	end

	always @(posedge mclk)
	begin
		if (!nrst)
		begin
			for (k = 0; k < NUM_FILT; k = k + 1)
			begin
				fid_q[k] <= `CAF_RST_WORD;
				fctl_q[k] <= `CAF_RST_FCTL;
			end
			for (k = 0; k < 4; k = k + 1)
				msk_q[k] <= `CAF_RST_WORD;
			data_filter_bit_count_q <= `CAF_RST_CNT;
		end
		else if (wb_wr)
		begin
			// Status and unmapped words acknowledge but keep nothing.
			if (sel_fid)
			begin
				if (!fctl_q[idx][`CAF_FEN_BIT])
					fid_q[idx] <= (fid_q[idx] & ~bmask) | (wb_dat_i & bmask); // RL17
			end
			else if (sel_msk)
			begin
				if (!mask_used_d[wb_adr_i[3:2]])
					msk_q[wb_adr_i[3:2]] <= (msk_q[wb_adr_i[3:2]] & ~bmask) | (wb_dat_i & bmask);
			end
			else if (sel_fctl)
			begin
				if (wb_sel_i[0])
					fctl_q[idx] <= wb_dat_i[7:0];
			end
			else if (sel_mctl && wb_sel_i[0])
				data_filter_bit_count_q <= wb_dat_i[4:0]; // RL8
		end
	end

	// The stage holds one message at a time, so no result can overtake another.
	always @*
	begin
		case (state_q)
			ST_IDLE:
				state_d = take_msg ? ST_EVAL : ST_IDLE;
			ST_EVAL:
				state_d = ST_IDLE;
			default:
				state_d = ST_IDLE;
		endcase
	end

	always @(posedge mclk)
	begin
		if (!nrst)
			state_q <= ST_IDLE;
		else
			state_q <= state_d;
	end

	// Capture into the assembly buffer, evaluate on the following cycle.
	always @(posedge mclk)
	begin
		if (!nrst)
		begin
			msg_ready <= 1'b1;
			mab_sid_q <= 11'h000;
			mab_eid_q <= 18'h0_0000;
			mab_ide_q <= 1'b0;
			mab_dlc_q <= 4'h0;
			mab_pay_q <= 18'h0_0000;
			store_valid <= 1'b0;
			store_fifo <= 5'h00;
			filter_hit_number <= 5'h00;
			ovfl_valid <= 1'b0;
			ovfl_fifo <= 5'h00;
			last_acc_q <= 1'b0;
			last_ovf_q <= 1'b0;
			last_fifo_q <= 5'h00;
			last_hit_q <= 5'h00;
		end
		else
		begin
			store_valid <= 1'b0;
			ovfl_valid <= 1'b0;
			if (state_q == ST_IDLE)
			begin
				if (take_msg)
				begin
					msg_ready <= 1'b0;
					mab_sid_q <= msg_sid;
					mab_eid_q <= msg_eid;
					mab_ide_q <= msg_ide;
					mab_dlc_q <= msg_dlc;
					mab_pay_q <= {msg_byte0, msg_byte1, msg_byte2[7:6]}; // RL11 RL12
				end
			end
			else
			begin
				msg_ready <= 1'b1;
				last_acc_q <= found;
				last_ovf_q <= any_hit & ~found;
				if (found)
				begin
					store_valid <= 1'b1; // RL1
					store_fifo <= fsel_flat[win*5 +: 5]; // RL3
					filter_hit_number <= win; // RL19
					last_fifo_q <= fsel_flat[win*5 +: 5];
					last_hit_q <= win;
				end
				else if (any_hit)
				begin
					// Every matching FIFO is full, so the message is dropped here.
					ovfl_valid <= 1'b1; // RL20
					ovfl_fifo <= first_fifo; // RL20
					last_fifo_q <= first_fifo;
				end
			end
		end
	end

endmodule

// ---- logic/caf_regs.vh ----
`ifndef CAF_REGS_VH
`define CAF_REGS_VH

// Register byte offsets on the bus.
`define CAF_OFS_FILT 9'h000
`define CAF_OFS_MASK 9'h080
`define CAF_OFS_FCTL 9'h100
`define CAF_OFS_MCTL 9'h180
`define CAF_OFS_STAT 9'h184

// Filter identifier and mask register fields.
`define CAF_SID_HI 31
`define CAF_SID_LO 21
`define CAF_TYPE_BIT 19
`define CAF_EID_HI 17

// Filter control register fields, one word per filter.
`define CAF_FSEL_HI 4
`define CAF_MSEL_HI 6
`define CAF_MSEL_LO 5
`define CAF_FEN_BIT 7

// Status register fields.
`define CAF_ST_HIT_LO 0
`define CAF_ST_FIFO_LO 8
`define CAF_ST_ACC_BIT 16
`define CAF_ST_OVF_BIT 17
`define CAF_ST_BUSY_BIT 31

// Data-field filtering limits, in payload bits.
`define CAF_DN_MAX 5'h12
`define CAF_DN_TWO_BYTES 5'h10
`define CAF_DN_ONE_BYTE 5'h08

// Reset values.
`define CAF_RST_WORD 32'h0000_0000
`define CAF_RST_FCTL 8'h00
`define CAF_RST_CNT 5'h00

`endif

// ---- logic/caf_match.v ----
`timescale 1ns/10ps
module caf_match
(
	input wire en,
	input wire ext_id_enable,
	input wire [10:0] fsid,
	input wire [17:0] feid,
	input wire mask_type_match,
	input wire [10:0] msid,
	input wire [17:0] meid,
	input wire ide,
	input wire [10:0] sid,
	input wire [17:0] eid,
	input wire dn_on,
	input wire [17:0] dpay,
	input wire [17:0] dlim,
	output wire hit
);

	wire type_ok;
	wire sid_ok;
	wire ext_ok;
	wire dat_ok;

	// A clear type bit in the mask lets both frame formats through.
	assign type_ok = ~mask_type_match | (ide == ext_id_enable);
	assign sid_ok = (((sid ^ fsid) & msid) == 11'h000); // RL18 RL9
	assign ext_ok = (((eid ^ feid) & meid) == 18'h0_0000); // RL18
	// Data bits only stand in for the extended part on standard frames.
	assign dat_ok = ~dn_on | (((dpay ^ feid) & meid & dlim) == 18'h0_0000); // RL9 RL10 RL16
	assign hit = en & type_ok & sid_ok & (ide ? ext_ok : dat_ok); // RL10

endmodule

// ---- logic/caf_prio.v ----
`timescale 1ns/10ps
module caf_prio
#(
	parameter NUM_FILT = 32
)
(
	input wire [NUM_FILT-1:0] hit,
	input wire [NUM_FILT*5-1:0] fsel_flat,
	input wire [31:0] fifo_full,
	output reg found,
	output reg [4:0] win,
	output reg any_hit,
	output reg [4:0] first_fifo
);

	integer i;

	// Walking downward leaves the lowest-numbered candidate in place.
	always @*
	begin
		found = 1'b0;
		win = 5'h00;
		any_hit = 1'b0;
		first_fifo = 5'h00;
		for (i = NUM_FILT - 1; i >= 0; i = i - 1)
		begin
			if (hit[i])
			begin
				any_hit = 1'b1;
				first_fifo = fsel_flat[i*5 +: 5]; // RL20
				if (!fifo_full[fsel_flat[i*5 +: 5]])
				begin
					found = 1'b1; // RL1
					win = i[4:0]; // RL2 RL3
				end
			end
		end
	end

endmodule

// ---- tb/caf_top_sva.sv ----
`timescale 1ns/10ps
module caf_top_sva
#(
	parameter NUM_FILT = 32
)
(
	input wire mclk,
	input wire nrst,
	input wire wb_cyc_i,
	input wire wb_stb_i,
	input wire wb_we_i,
	input wire wb_ack_o,
	input wire msg_valid,
	input wire msg_ready,
	input wire [31:0] fifo_full,
	input wire store_valid,
	input wire [4:0] store_fifo,
	input wire ovfl_valid,
	input wire [4:0] ovfl_fifo
);
	reg [31:0] full_q;
	// Full flags as they stood in the evaluation cycle.
	always @(posedge mclk)
		full_q <= fifo_full;
	default clocking @(posedge mclk); endclocking
	default disable iff (!nrst);
	chk_one_dest: assert property (!(store_valid && ovfl_valid))
		else $error("store and overflow together");
	chk_room_used: assert property (store_valid |-> !full_q[store_fifo])
		else $error("stored into a full fifo");
	chk_ovfl_full: assert property (ovfl_valid |-> full_q[ovfl_fifo])
		else $error("overflow on a fifo with room");
	chk_result_lag: assert property ((store_valid || ovfl_valid) |-> $past(msg_valid && msg_ready, 2))
		else $error("result without a message");
	chk_result_single: assert property (store_valid |=> !store_valid && !ovfl_valid)
		else $error("second result for one message");
	chk_ready_gap: assert property (msg_valid && msg_ready |=> !msg_ready ##1 msg_ready)
		else $error("ready not low for one cycle");
	chk_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
		else $error("ack longer than one cycle");
	chk_ack_bound: assert property ($rose(wb_cyc_i && wb_stb_i) |-> ##[1:2] wb_ack_o)
		else $error("ack late");
	cover property (store_valid);
	cover property (ovfl_valid);
	cover property (wb_ack_o && wb_we_i);
endmodule
bind caf_top caf_top_sva #(.NUM_FILT(NUM_FILT)) chk (.mclk(mclk), .nrst(nrst),
	.wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_ack_o(wb_ack_o),
	.msg_valid(msg_valid), .msg_ready(msg_ready), .fifo_full(fifo_full),
	.store_valid(store_valid), .store_fifo(store_fifo), .ovfl_valid(ovfl_valid),
	.ovfl_fifo(ovfl_fifo));

// ---- tb/caf_node.sv ----
`timescale 1ns/10ps
module caf_node
(
	input wire mclk,
	input wire msg_ready,
	output reg msg_valid,
	output reg [10:0] msg_sid,
	output reg [17:0] msg_eid,
	output reg msg_ide,
	output reg [3:0] msg_dlc,
	output reg [23:0] msg_pay
);
	initial
	begin
		msg_valid = 1'h0;
		{msg_sid, msg_eid, msg_ide, msg_dlc, msg_pay} = 58'h0;
	end
	task send(input [10:0] s, input [17:0] e, input i, input [3:0] d, input [23:0] p);
	begin
		@(posedge mclk);
		msg_valid <= 1'h1;
		{msg_sid, msg_eid, msg_ide, msg_dlc, msg_pay} <= {s, e, i, d, p};
		@(posedge mclk);
		while (msg_ready !== 1'h1)
			@(posedge mclk);
		msg_valid <= 1'h0;
		// Released fields flip so a stale message can never look fresh.
		{msg_sid, msg_eid, msg_ide, msg_dlc, msg_pay} <= ~{s, e, i, d, p};
	end
	endtask
endmodule

// ---- tb/can_acceptance_filter_priority_test.sv ----
`timescale 1ns/10ps
module can_acceptance_filter_priority_test;
	reg mclk, nrst, cyc, stb, we;
	reg [8:2] adr;
	reg [3:0] sel;
	reg [31:0] dat, fifo_full, seed, q, fc;
	wire [31:0] rdat;
	wire ack, mv, mr, mi, sv, ov;
	wire [10:0] ms;
	wire [17:0] me;
	wire [3:0] md;
	wire [23:0] mp;
	wire [4:0] sf, hn, of;
	logic [31:0] fid [32];
	logic [31:0] msk [4];
	logic [7:0] fct [32];
	int cnt, fail_count, comparisons, cyc_n, j, s_acc, s_ovf, s_fifo, s_hit;
	int cnts [9] = '{0, 3, 8, 9, 16, 17, 18, 25, 31};
	caf_node node (.mclk(mclk), .msg_ready(mr), .msg_valid(mv), .msg_sid(ms), .msg_eid(me),
		.msg_ide(mi), .msg_dlc(md), .msg_pay(mp));
	caf_top dut (.mclk(mclk), .nrst(nrst), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
		.wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(rdat), .wb_ack_o(ack),
		.msg_valid(mv), .msg_sid(ms), .msg_eid(me), .msg_ide(mi), .msg_dlc(md),
		.msg_byte0(mp[23:16]), .msg_byte1(mp[15:8]), .msg_byte2(mp[7:0]),
		.fifo_full(fifo_full), .msg_ready(mr), .store_valid(sv), .store_fifo(sf),
		.filter_hit_number(hn), .ovfl_valid(ov), .ovfl_fifo(of));
	always #2.5 mclk = ~mclk;
	task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
	begin
		comparisons++;
		if (seen !== exp)
		begin
			fail_count++;
			$display("[ERR] %s expected %h seen %h", nm, exp, seen);
		end
	end
	endtask
	task finish_test;
	begin
		$display("comparisons %0d fail_count %0d", comparisons, fail_count);
		if (fail_count == 0 && comparisons > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	end
	endtask
	always @(posedge mclk)
	begin
		cyc_n++;
		if (cyc_n == 40000)
		begin
			fail_count++;
			finish_test;
		end
	end
	task bus(input w, input [8:2] a, input [31:0] d);
	begin
		@(posedge mclk);
		{cyc, stb, we, adr, dat, sel} <= {2'h3, w, a, d, 4'hf};
		@(posedge mclk);
		while (ack !== 1'h1)
			@(posedge mclk);
		q = rdat;
		{cyc, stb} <= 2'h0;
	end
	endtask
	task wr(input [8:2] a, input [31:0] d);
	begin
		bus(1'h1, a, d);
		if (a < 7'h20 && !fct[a[6:2]][7])
			fid[a[6:2]] = d;
		else if (a >= 7'h20 && a < 7'h24)
			msk[a[3:2]] = d;
		else if (a >= 7'h40 && a < 7'h60)
			fct[a[6:2]] = d[7:0];
		else if (a == 7'h60)
			cnt = d[4:0];
	end
	endtask
	task msg;
		int n, k, i, h, f, o;
		bit m, st, any;
		logic [31:0] r, ff, fw, mk, e, p;
	begin
		r = $random(seed);
		ff = $random(seed) & $random(seed);
		e = $random(seed);
		p = $random(seed);
		i = r[4];
		n = cnt > 18 ? 18 : cnt;
		if (r[3:0] % 9 == 0)
			n = 0;
		else if (r[3:0] % 9 == 1 && n > 8)
			n = 8;
		else if (r[3:0] % 9 == 2 && n > 16)
			n = 16;
		if (i)
			n = 0;
		@(posedge mclk);
		fifo_full <= ff;
		// The model works from the values sent, not from the port after release.
		node.send({9'h0, r[6:5]}, e[17:0], i, r[3:0] % 9, p[23:0]);
		{st, any, h, f, o} = 0;
		for (j = 0; j < 32; j++)
		begin
			fw = fid[j];
			mk = msk[fct[j][6:5]];
			m = fct[j][7] && ((fw[31:21] ^ {9'h0, r[6:5]}) & mk[31:21]) == 0;
			if (mk[19] && fw[19] != i)
				m = 0;
			if (i && ((fw[17:0] ^ e[17:0]) & mk[17:0]) != 0)
				m = 0;
			for (k = 0; k < n; k++)
				if (mk[n-1-k] && p[23-k] != fw[n-1-k])
					m = 0;
			if (m && !any)
				{any, o} = {1'b1, 27'h0, fct[j][4:0]};
			if (m && !st && !ff[fct[j][4:0]])
				{st, f, h} = {1'b1, 27'h0, fct[j][4:0], j};
		end
		s_acc = st;
		s_ovf = any && !st;
		if (st)
			{s_fifo, s_hit} = {f, h};
		else if (any)
			s_fifo = o;
		@(posedge mclk);
		@(negedge mclk);
		chk("store", sv, st);
		chk("overflow", ov, any && !st);
		if (st)
			chk("fifo hit", {sf, hn}, {f[4:0], h[4:0]});
		if (any && !st)
			chk("ovfl fifo", of, o);
	end
	endtask
	initial
	begin
		{mclk, nrst, cyc, stb, we, adr, sel, dat, fifo_full} = 0;
		seed = 32'hb0f1_4be7;
		repeat (6) @(posedge mclk);
		nrst <= 1'h1;
		bus(1'h0, 7'h05, 32'h0000_0000);
		chk("reset id", q, 32'h0000_0000);
		bus(1'h0, 7'h7f, 32'h0000_0000);
		chk("unmapped", q, 32'h0000_0000);
		for (j = 0; j < 32; j++)
			fct[j] = 8'h00;
		for (j = 0; j < 4; j++)
			wr(7'h20 + j, $random(seed) & ($random(seed) | 32'hffe0_0000));
		for (j = 0; j < 32; j++)
			wr(j, $random(seed) & 32'h0068_ffff);
		wr(7'h60, 32'h0000_0000);
		for (j = 0; j < 32; j++)
		begin
			fc = $random(seed) | 32'h0000_0080;
			wr(7'h40 + j, fc & 32'h0000_007f);
			wr(7'h40 + j, fc);
		end
		// Enabled filters must keep their identifiers through a write.
		for (j = 0; j < 4; j++)
		begin
			wr(j, 32'hffff_ffff);
			bus(1'h0, j, 32'h0000_0000);
			chk("id lock", q, fid[j]);
		end
		foreach (cnts[c])
		begin
			wr(7'h60, cnts[c]);
			repeat (60) msg();
			bus(1'h0, 7'h61, 32'h0000_0000);
			chk("status", q, {14'h0000, s_ovf[0], s_acc[0], 3'h0, s_fifo[4:0], 3'h0, s_hit[4:0]});
		end
		finish_test;
	end
endmodule
